// *** pbc_defs.svh ***
// register indices, field positions and reset values of the phase b calibration bank
// ============================================================================
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// ============================================================================
// register indices (byte address is four times the index)
`define PBC_IDX_GAIN1      10'h022
`define PBC_IDX_GAIN2      10'h023
`define PBC_IDX_GAIN3      10'h024
`define PBC_IDX_GAIN4      10'h025
`define PBC_IDX_PHCAL0     10'h026
`define PBC_IDX_PHCAL1     10'h027
`define PBC_IDX_PHCAL2     10'h028
`define PBC_IDX_PHCAL3     10'h029
`define PBC_IDX_PHCAL4     10'h02A
`define PBC_IDX_VGAIN      10'h02B
`define PBC_IDX_IRMSOS     10'h02C
`define PBC_IDX_VRMSOS     10'h02D
`define PBC_IDX_PGAIN      10'h02E
`define PBC_IDX_WATTOS     10'h02F
`define PBC_IDX_GAIN0      10'h0F0
`define PBC_IDX_GAIN5      10'h0F1
`define PBC_IDX_CONFIG     10'h0F2
`define PBC_IDX_STATUS     10'h0F3
`define PBC_IDX_LTHR0      10'h0F8
`define PBC_IDX_HTHR0      10'h100

// ============================================================================
// storage slots of the register array
`define PBC_SLOT_GAIN1     5'h00
`define PBC_SLOT_PHCAL0    5'h04
`define PBC_SLOT_VGAIN     5'h09
`define PBC_SLOT_IRMSOS    5'h0A
`define PBC_SLOT_VRMSOS    5'h0B
`define PBC_SLOT_PGAIN     5'h0C
`define PBC_SLOT_WATTOS    5'h0D
`define PBC_SLOT_GAIN0     5'h0E
`define PBC_SLOT_GAIN5     5'h0F
`define PBC_SLOT_LTHR0     5'h10
`define PBC_SLOT_HTHR0     5'h15
`define PBC_SLOT_CONFIG    5'h1A
`define PBC_SLOT_STATUS    5'h1B
`define PBC_NUM_RW         27
`define PBC_NUM_THR        5

// ============================================================================
// fields, reset values, bus answers
`define PBC_CFG_MULTIPOINT_COMP_ENABLE_BIT   0
`define PBC_RESET_VALUE    32'h0000_0000
`define PBC_BAND_MAX       3'h5
`define PBC_PH_MAX         3'h4
`define PBC_RESP_OKAY      2'h0
`define PBC_RESP_SLVERR    2'h2

`endif

// *** pbc_pkg.sv ***
// types shared by the phase b calibration bank
package pbc_pkg;

    // ========================================================================
    // current band, 0 = lowest amplitude
    typedef logic [2:0] pbc_band_t;

    // decoded register address
    typedef struct packed {
        logic       valid;
        logic       rdonly;
        logic [4:0] slot;
    } pbc_slot_s;

    // calibration values handed to the datapath
    typedef struct packed {
        logic        mp_gain_on;
        logic [31:0] mp_gain;
        logic [31:0] phase_corr;
        logic [31:0] volt_gain;
        logic [31:0] irms_os;
        logic [31:0] vrms_os;
        logic [31:0] power_gain;
        logic [31:0] watt_os;
        pbc_band_t   band;
    } pbc_cal_s;

endpackage

// *** pbc_regs.sv ***
// phase b calibration register bank with axi4-lite slave and band selection
`timescale 1ns/1ps
`include "pbc_defs.svh"

module pbc_regs
    import pbc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // axi4-lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // measured amplitude and calibration outputs
    input  wire logic [31:0] phase_b_current_rms,
    output pbc_cal_s         cal
);

    // ========================================================================
    // address decode, shared by the write and read paths
    function automatic pbc_slot_s decode(input logic [9:0] idx);
        pbc_slot_s s;
        s = '0;
        if (idx >= `PBC_IDX_GAIN1 && idx <= `PBC_IDX_WATTOS)
        begin
            s.valid = 1'b1;
            s.slot  = 5'(idx - `PBC_IDX_GAIN1);
        end
        else if (idx >= `PBC_IDX_LTHR0 && idx < `PBC_IDX_LTHR0 + 10'(`PBC_NUM_THR))
        begin
            s.valid = 1'b1;
            s.slot  = `PBC_SLOT_LTHR0 + 5'(idx - `PBC_IDX_LTHR0);
        end
        else if (idx >= `PBC_IDX_HTHR0 && idx < `PBC_IDX_HTHR0 + 10'(`PBC_NUM_THR))
        begin
            s.valid = 1'b1;
            s.slot  = `PBC_SLOT_HTHR0 + 5'(idx - `PBC_IDX_HTHR0);
        end
        else
        begin
            case (idx)
                `PBC_IDX_GAIN0:  begin s.valid = 1'b1; s.slot = `PBC_SLOT_GAIN0;  end
                `PBC_IDX_GAIN5:  begin s.valid = 1'b1; s.slot = `PBC_SLOT_GAIN5;  end
                `PBC_IDX_CONFIG: begin s.valid = 1'b1; s.slot = `PBC_SLOT_CONFIG; end
                `PBC_IDX_STATUS:
                begin
                    s.valid  = 1'b1;
                    s.rdonly = 1'b1;
                    s.slot   = `PBC_SLOT_STATUS;
                end
                default: s = '0;
            endcase
        end
        return s;
    endfunction

    // merge write data under the byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                m[8*b +: 8] = data[8*b +: 8];
        end
        return m;
    endfunction

    // ========================================================================
    // storage
    logic [31:0] regs [0:`PBC_NUM_RW-1];
    logic        aw_held;
    logic        w_held;
    logic [9:0]  aw_idx;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    pbc_band_t   band;
    pbc_slot_s   wslot;
    pbc_slot_s   rslot;
    logic        do_write;
    logic        multipoint_comp_enable;

    assign multipoint_comp_enable     = regs[`PBC_SLOT_CONFIG][`PBC_CFG_MULTIPOINT_COMP_ENABLE_BIT];
    assign wslot    = decode(aw_idx);
    assign rslot    = decode(s_axi_araddr[11:2]);
    // write goes ahead only once both halves are in and no response is pending
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // handshake outputs are combinational, one transfer in flight per direction
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // ========================================================================
    // write address and data capture, either order
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_idx  <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_idx  <= s_axi_awaddr[11:2];
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    // write response; unmapped or read-only targets answer slverr
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PBC_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wslot.valid && !wslot.rdonly) ? `PBC_RESP_OKAY
                                                           : `PBC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ========================================================================
    // register array, every slot resets to zero
    generate
        for (genvar i = 0; i < `PBC_NUM_RW; i++)
        begin : g_reg
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                    regs[i] <= `PBC_RESET_VALUE;
                else if (do_write && wslot.valid && !wslot.rdonly && wslot.slot == 5'(i))
                    regs[i] <= merge(regs[i], w_data, w_strb);
            end
        end
    endgenerate

    // ========================================================================
    // read channel; data captured at the address handshake
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `PBC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rslot.valid ? `PBC_RESP_OKAY : `PBC_RESP_SLVERR;
            if (!rslot.valid)
                s_axi_rdata <= '0;
            else if (rslot.rdonly)
                s_axi_rdata <= {28'h0, multipoint_comp_enable, band}; // live band and enable
            else
                s_axi_rdata <= regs[rslot.slot];
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ========================================================================
    // amplitude band with hysteresis: step up past the high threshold,
    // step down below the low one; one step per cycle keeps it from skipping
    always_ff @(posedge ref_clk)
    begin
        if (srst || !multipoint_comp_enable)
            band <= '0;
        else if (band < `PBC_BAND_MAX
                 && phase_b_current_rms > regs[`PBC_SLOT_HTHR0 + 5'(band)])
            band <= band + 3'h1;
        else if (band != '0
                 && phase_b_current_rms < regs[`PBC_SLOT_LTHR0 + 5'(band) - 5'h1])
            band <= band - 3'h1;
    end

    // ========================================================================
    // factor selection by band
    logic [31:0] next_gain;
    logic [31:0] next_phase;
    pbc_band_t   ph_band;

    // only five phase factors; the top band shares the fifth
    assign ph_band = (band > `PBC_PH_MAX) ? `PBC_PH_MAX : band;

    always_comb
    begin
        case (band)
            3'h0:    next_gain = regs[`PBC_SLOT_GAIN0];
            3'h5:    next_gain = regs[`PBC_SLOT_GAIN5];
            default: next_gain = regs[`PBC_SLOT_GAIN1 + 5'(band) - 5'h1];
        endcase
        if (multipoint_comp_enable)
            next_phase = regs[`PBC_SLOT_PHCAL0 + 5'(ph_band)];
        else
            next_phase = regs[`PBC_SLOT_PHCAL0];
    end

    // calibration outputs registered, one cycle behind the registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cal <= '0;
        else
        begin
            cal.mp_gain_on <= multipoint_comp_enable;
            cal.mp_gain    <= multipoint_comp_enable ? next_gain : '0;
            cal.phase_corr <= next_phase;
            cal.volt_gain  <= regs[`PBC_SLOT_VGAIN];
            cal.irms_os    <= regs[`PBC_SLOT_IRMSOS];
            cal.vrms_os    <= regs[`PBC_SLOT_VRMSOS];
            cal.power_gain <= regs[`PBC_SLOT_PGAIN];
            cal.watt_os    <= regs[`PBC_SLOT_WATTOS];
            cal.band       <= band;
        end
    end

    // ========================================================================
    // checks
    chk_gain_pick: assert property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable |=> cal.mp_gain_on && cal.mp_gain == $past(next_gain) && cal.band == $past(band))
        else $error("multipoint gain factor not taken from current band");

    chk_gain_off: assert property (@(posedge ref_clk) disable iff (srst)
        !multipoint_comp_enable |=> !cal.mp_gain_on && cal.mp_gain == 32'h0000_0000)
        else $error("multipoint gain applied while disabled");

    chk_phase_zero: assert property (@(posedge ref_clk) disable iff (srst)
        !multipoint_comp_enable |=> cal.phase_corr == $past(regs[`PBC_SLOT_PHCAL0]))
        else $error("phase factor other than zero used while disabled");

    chk_phase_pick: assert property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable |=> cal.phase_corr == $past(regs[`PBC_SLOT_PHCAL0 + 5'(ph_band)]))
        else $error("phase factor not taken from current band");

    chk_band_step: assert property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable && $past(multipoint_comp_enable) && band != $past(band) |->
            band == $past(band) + 3'h1 || band == $past(band) - 3'h1)
        else $error("band moved more than one step");

    chk_volt_gain: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 cal.volt_gain == $past(regs[`PBC_SLOT_VGAIN]))
        else $error("voltage gain output stale");

    chk_rms_offsets: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 cal.irms_os == $past(regs[`PBC_SLOT_IRMSOS])
            && cal.vrms_os == $past(regs[`PBC_SLOT_VRMSOS]))
        else $error("rms offset outputs stale");

    chk_power_path: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 cal.power_gain == $past(regs[`PBC_SLOT_PGAIN])
            && cal.watt_os == $past(regs[`PBC_SLOT_WATTOS]))
        else $error("power gain or watt offset output stale");

    chk_bresp_hold: assert property (@(posedge ref_clk) disable iff (srst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accepted");

    // band walk: cleared while disabled, one step each way when a threshold is crossed
    chk_band_clear: assert property (@(posedge ref_clk) disable iff (srst)
        !multipoint_comp_enable |=> band == 3'h0)
        else $error("band kept while multipoint disabled");

    chk_band_rise: assert property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable && band < `PBC_BAND_MAX
            && phase_b_current_rms > regs[`PBC_SLOT_HTHR0 + 5'(band)]
        |=> band == $past(band) + 3'h1)
        else $error("band did not step up past the high threshold");

    chk_band_fall: assert property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable && band != 3'h0
            && !(band < `PBC_BAND_MAX
                 && phase_b_current_rms > regs[`PBC_SLOT_HTHR0 + 5'(band)])
            && phase_b_current_rms < regs[`PBC_SLOT_LTHR0 + 5'(band) - 5'h1]
        |=> band == $past(band) - 3'h1)
        else $error("band did not step down below the low threshold");

    // bus side: answers, stored words and refused targets
    chk_read_answer: assert property (@(posedge ref_clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing one cycle after the address");

    chk_write_lands: assert property (@(posedge ref_clk) disable iff (srst)
        do_write && wslot.valid && !wslot.rdonly && w_strb == 4'hF
        |=> regs[$past(wslot.slot)] == $past(w_data))
        else $error("full word write did not reach its register");

    chk_slverr_write: assert property (@(posedge ref_clk) disable iff (srst)
        do_write && !(wslot.valid && !wslot.rdonly)
        |=> s_axi_bvalid && s_axi_bresp == `PBC_RESP_SLVERR)
        else $error("write to unmapped or read-only target not refused");

    chk_status_word: assert property (@(posedge ref_clk) disable iff (srst)
        s_axi_arvalid && s_axi_arready && rslot.valid && rslot.rdonly
        |=> s_axi_rdata == {28'h0, $past(multipoint_comp_enable), $past(band)})
        else $error("status word does not show enable and band");

    cov_top_band: cover property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable && band == `PBC_BAND_MAX);
    cov_band_down: cover property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable && band == 3'h2 ##1 band == 3'h1);
    cov_write_then_read: cover property (@(posedge ref_clk) disable iff (srst)
        s_axi_bvalid && s_axi_bready ##[1:4] s_axi_rvalid);
    cov_unmapped: cover property (@(posedge ref_clk) disable iff (srst)
        s_axi_rvalid && s_axi_rresp == `PBC_RESP_SLVERR);
    cov_mp_off_top: cover property (@(posedge ref_clk) disable iff (srst)
        multipoint_comp_enable && band == `PBC_BAND_MAX ##1 !multipoint_comp_enable);

endmodule // pbc_regs

// *** pbc_tb.sv ***
// self-checking testbench of the phase b calibration register bank
`timescale 1ns/1ps
`include "pbc_defs.svh"

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench
    import pbc_pkg::*;
;
    // ========================================================================
    // clock, reset and design pins
    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic [11:0] awaddr  = 12'h000;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready  = 1'b0;
    logic [11:0] araddr  = 12'h000;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready  = 1'b0;
    logic [31:0] rms     = 32'h0000_0000;
    pbc_cal_s    cal;
    int          fails    = 0;
    int          compares = 0;
    int          cycles   = 0;
    logic [31:0] rd;
    logic [1:0]  rs;

    always #4 ref_clk = ~ref_clk;

    pbc_regs dut_u (
        .ref_clk(ref_clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .phase_b_current_rms(rms), .cal(cal)
    );

    // ========================================================================
    // verdict, reached from the main sequence or from the hang guard
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fails++;
            summarize();
        end
    end

    // ========================================================================
    // bus master tasks: address and data offered together, response held ready
    task automatic axw(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
        @(posedge ref_clk);
        awaddr  <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // full-word write that must be accepted
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [1:0] r;
        axw(idx, d, 4'hF, r);
        `CHK("write response", `PBC_RESP_OKAY, r)
    endtask

    // patterns: calibration words and multipoint factors
    function automatic logic [31:0] pat(input logic [9:0] idx);
        return {8'hA5, 14'h0000, idx};
    endfunction

    function automatic logic [9:0] gidx(input int k);
        return (k == 0) ? `PBC_IDX_GAIN0 : (k == 5) ? `PBC_IDX_GAIN5 : 10'(34 + k - 1);
    endfunction

    // ========================================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        // reset values of the fourteen calibration words from GAIN1 to WATTOS
        `CHK("cal after reset", 228'h0, cal)
        for (int i = 0; i < 14; i++)
        begin
            axr(10'(34 + i), rd, rs);
            `CHK("reset value", `PBC_RESET_VALUE, rd)
            `CHK("read response", `PBC_RESP_OKAY, rs)
        end
        $display("test reset_values done");

        // write the fourteen words from GAIN1 to WATTOS, read them back, see phase factor zero and the fixed words reach the calibration outputs
        for (int i = 0; i < 14; i++)
            wr(10'(34 + i), pat(10'(34 + i)));
        for (int i = 0; i < 14; i++)
        begin
            axr(10'(34 + i), rd, rs);
            `CHK("readback", pat(10'(34 + i)), rd)
        end
        `CHK("mp gain on", 1'b0, cal.mp_gain_on)
        `CHK("mp gain off", 32'h0, cal.mp_gain)
        `CHK("phase corr zero", pat(`PBC_IDX_PHCAL0), cal.phase_corr)
        `CHK("volt gain", pat(`PBC_IDX_VGAIN), cal.volt_gain)
        `CHK("irms offset", pat(`PBC_IDX_IRMSOS), cal.irms_os)
        `CHK("vrms offset", pat(`PBC_IDX_VRMSOS), cal.vrms_os)
        `CHK("power gain", pat(`PBC_IDX_PGAIN), cal.power_gain)
        `CHK("watt offset", pat(`PBC_IDX_WATTOS), cal.watt_os)
        $display("test write_readback done");

        // byte lanes, unmapped places and the read-only status word
        wr(`PBC_IDX_VGAIN, 32'h1111_2222);
        axw(`PBC_IDX_VGAIN, 32'hFFFF_FFFF, 4'h5, rs);
        `CHK("strobed write resp", `PBC_RESP_OKAY, rs)
        repeat (2) @(posedge ref_clk);
        `CHK("strobed gain", 32'h11FF_22FF, cal.volt_gain)
        axr(10'h3FF, rd, rs);
        `CHK("unmapped read resp", `PBC_RESP_SLVERR, rs)
        `CHK("unmapped read data", 32'h0, rd)
        axw(10'h3FF, 32'h1234_5678, 4'hF, rs);
        `CHK("unmapped write resp", `PBC_RESP_SLVERR, rs)
        axw(`PBC_IDX_STATUS, 32'hFFFF_FFFF, 4'hF, rs);
        `CHK("status write resp", `PBC_RESP_SLVERR, rs)
        $display("test access_errors done");

        // multipoint: high k = 100k+100, low k = 100k+50; rms 100k+25 settles in band k
        for (int k = 0; k < 6; k++)
            wr(gidx(k), {8'hC0, 20'h00000, 4'(k)});
        for (int k = 0; k < 5; k++)
        begin
            wr(10'(38 + k), {8'hD0, 20'h00000, 4'(k)});
            wr(10'(`PBC_IDX_LTHR0 + k), 32'(100 * k + 50));
            wr(10'(`PBC_IDX_HTHR0 + k), 32'(100 * k + 100));
        end
        wr(`PBC_IDX_CONFIG, 32'h0000_0001);
        for (int j = 0; j < 12; j++)
        begin
            int k;
            k = (j < 6) ? j : 11 - j;
            @(posedge ref_clk) rms <= 32'(100 * k + 25);
            repeat (10) @(posedge ref_clk);
            `CHK("band", 3'(k), cal.band)
            `CHK("mp enable", 1'b1, cal.mp_gain_on)
            `CHK("mp gain", {8'hC0, 20'h00000, 4'(k)}, cal.mp_gain)
            `CHK("mp phase", {8'hD0, 20'h00000, 4'((k > 4) ? 4 : k)}, cal.phase_corr)
            axr(`PBC_IDX_STATUS, rd, rs);
            `CHK("status", {28'h0, 1'b1, 3'(k)}, rd)
        end
        // leaving the top band with multipoint switched off
        @(posedge ref_clk) rms <= 32'd525;
        repeat (10) @(posedge ref_clk);
        wr(`PBC_IDX_CONFIG, 32'h0000_0000);
        // one edge on the band is still at the top: phase must already be factor zero
        @(posedge ref_clk);
        `CHK("off phase early", 32'hD000_0000, cal.phase_corr)
        repeat (2) @(posedge ref_clk);
        `CHK("off band", 3'h0, cal.band)
        `CHK("off gain", 32'h0, cal.mp_gain)
        `CHK("off phase", 32'hD000_0000, cal.phase_corr)
        $display("test multipoint done");
        summarize();
    end
endmodule // testbench
